// ### src/flow_meter_ctrl.sv
/*
 Start-up sequencer, unit and table store and totalizer,
 with an APB register slave. Assumes flow_rate, flow_pct,
 table_valid and total_restore come from pclk logic; the
 maintenance button is an asynchronous pin.
*/
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module flow_meter_ctrl #(
    parameter int unsigned SEC_CYCLES = flow_meter_pkg::SEC_CYCLES
) (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire flow_meter_pkg::apb_req_type  apb_req,
    output      flow_meter_pkg::apb_rsp_type  apb_rsp,
    input  wire logic [15:0]                  flow_rate,
    input  wire logic [7:0]                   flow_pct,
    input  wire logic [9:0]                   table_valid,
    input  wire logic [31:0]                  total_restore,
    input  wire logic                         maint_button,
    output      flow_meter_pkg::disp_type     disp,
    output      logic                         led_amber,
    output      logic                         led_green,
    output      logic [4:0]                   rate_unit,
    output      logic [3:0]                   user_total_unit,
    output      logic [3:0]                   table_sel,
    output      logic                         gas_uncal,
    output      logic [31:0]                  total,
    output      logic                         stop_hit
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0]               tick;
        flow_meter_pkg::phase_type phase;
        logic [1:0]                ph_sec;
        logic [8:0]                warm_left;
        logic [2:0]                warm_min;
        logic [5:0]                warm_sec;
        logic [1:0]                alt_sec;
        logic                      line2_warm;
        logic                      amber;
        logic                      green;
        logic                      loaded;
        logic                      btn1;
        logic                      btn2;
        logic                      tot_en;
        logic                      diag_en;
        logic [4:0]                unit;
        logic [3:0]                tot_unit;
        logic [3:0]                table_sel;
        logic                      uncal;
        logic [7:0]                start_pct;
        logic [31:0]               preset;
        logic [31:0]               total;
        logic                      stop;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
    } state_type;

    state_type s_q;
    state_type s_d;

    logic        sec_tick;
    logic        setup;
    logic        wr;
    logic        clr_wr;
    logic        mapped;
    logic [32:0] sum;
    logic [31:0] rdata;

    always_comb begin
        sec_tick = (s_q.tick == SEC_CYCLES - 1);
        setup    = apb_req.psel && !apb_req.penable;
        wr       = apb_req.psel && apb_req.penable && s_q.pready && apb_req.pwrite;
        clr_wr   = wr && (apb_req.paddr == flow_meter_pkg::ADDR_CTRL)
                   && apb_req.pwdata[flow_meter_pkg::CTRL_CLR_BIT];
        sum      = {1'b0, s_q.total} + {17'h0_0000, flow_rate};
        case (apb_req.paddr)
            flow_meter_pkg::ADDR_CTRL,
            flow_meter_pkg::ADDR_UNIT,
            flow_meter_pkg::ADDR_TABLE,
            flow_meter_pkg::ADDR_START,
            flow_meter_pkg::ADDR_PRESET,
            flow_meter_pkg::ADDR_TOTAL,
            flow_meter_pkg::ADDR_STATUS: mapped = 1'b1;
            default:                     mapped = 1'b0;
        endcase
        case (apb_req.paddr)
            flow_meter_pkg::ADDR_CTRL:   rdata = {29'h0, s_q.diag_en, 1'b0, s_q.tot_en};
            flow_meter_pkg::ADDR_UNIT:   rdata = {23'h0, s_q.tot_unit, s_q.unit};
            flow_meter_pkg::ADDR_TABLE:  rdata = {27'h0, s_q.uncal, s_q.table_sel};
            flow_meter_pkg::ADDR_START:  rdata = {24'h0, s_q.start_pct};
            flow_meter_pkg::ADDR_PRESET: rdata = s_q.preset;
            flow_meter_pkg::ADDR_TOTAL:  rdata = s_q.total;
            flow_meter_pkg::ADDR_STATUS: rdata = {27'h0, s_q.phase, s_q.stop, s_q.green, s_q.amber};
            default:                     rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d      = s_q;
        s_d.tick = sec_tick ? 32'h0 : s_q.tick + 32'h1;

        // Button pin synchroniser
        s_d.btn1 = maint_button;
        s_d.btn2 = s_q.btn1;

        // Banner sequence
        if (sec_tick && s_q.phase != flow_meter_pkg::PH_MAIN) begin
            if (s_q.ph_sec == 2'(flow_meter_pkg::BANNER_SECS - 1)) begin
                s_d.ph_sec = 2'h0;
                if (s_q.phase == flow_meter_pkg::PH_BANNER1) begin
                    s_d.phase = flow_meter_pkg::PH_BANNER2;
                end else begin
                    s_d.phase = flow_meter_pkg::PH_MAIN;
                end
            end else begin
                s_d.ph_sec = s_q.ph_sec + 2'h1;
            end
        end

        // Warm-up countdown and line two alternation
        if (sec_tick && s_q.warm_left != 9'h0) begin
            s_d.warm_left = s_q.warm_left - 9'h1;
            if (s_q.alt_sec == 2'(flow_meter_pkg::ALT_SECS - 1)) begin
                s_d.alt_sec    = 2'h0;
                s_d.line2_warm = s_q.diag_en && !s_q.line2_warm;
            end else begin
                s_d.alt_sec = s_q.alt_sec + 2'h1;
            end
        end
        if (!s_q.diag_en || s_d.warm_left == 9'h0) begin
            s_d.line2_warm = 1'b0;
        end
        s_d.amber = (s_d.warm_left != 9'h0);
        s_d.green = (s_d.warm_left == 9'h0);
        // Minutes:seconds kept in flops so the display pins are registered
        s_d.warm_min = 3'(s_d.warm_left / 9'h03c);
        s_d.warm_sec = 6'(s_d.warm_left % 9'h03c);

        // Stored total taken once after reset release
        if (!s_q.loaded) begin
            s_d.loaded = 1'b1;
            s_d.total  = total_restore;
        end

        // Register writes
        if (wr) begin
            case (apb_req.paddr)
                flow_meter_pkg::ADDR_CTRL: begin
                    s_d.tot_en  = apb_req.pwdata[flow_meter_pkg::CTRL_EN_BIT];
                    s_d.diag_en = apb_req.pwdata[flow_meter_pkg::CTRL_DIAG_BIT];
                end
                flow_meter_pkg::ADDR_UNIT: begin
                    // Out of range index ignored
                    if (apb_req.pwdata[31:0] <= 32'(flow_meter_pkg::UNIT_USER)) begin
                        s_d.unit = apb_req.pwdata[4:0];
                    end
                end
                flow_meter_pkg::ADDR_TABLE: begin
                    if (apb_req.pwdata[31:0] <= 32'(flow_meter_pkg::TABLE_LAST)) begin
                        s_d.table_sel = apb_req.pwdata[3:0];
                    end
                end
                flow_meter_pkg::ADDR_START:  s_d.start_pct = apb_req.pwdata[7:0];
                flow_meter_pkg::ADDR_PRESET: s_d.preset = apb_req.pwdata;
                default: begin
                end
            endcase
        end
        s_d.tot_unit = flow_meter_pkg::tot_unit_of(s_d.unit);
        s_d.uncal    = !table_valid[s_d.table_sel];

        // Totalizer; clamp at preset so equality is reached exactly
        if (s_q.loaded && s_q.tot_en && sec_tick && !s_q.stop
            && flow_pct >= s_q.start_pct) begin
            if (s_q.preset != 32'h0 && sum > {1'b0, s_q.preset}) begin
                s_d.total = s_q.preset;
            end else if (sum[32]) begin
                s_d.total = 32'hffff_ffff;
            end else begin
                s_d.total = sum[31:0];
            end
        end
        if (clr_wr) begin
            s_d.total = 32'h0;
        end
        // Button held through the banners clears the total
        if (s_q.loaded && s_q.btn2 && s_q.phase != flow_meter_pkg::PH_MAIN) begin
            s_d.total = 32'h0;
        end
        s_d.stop = (s_d.preset != 32'h0) && (s_d.total == s_d.preset);

        // APB: one access cycle, no wait states
        s_d.pready = setup;
        if (setup) begin
            s_d.pslverr = !mapped;
            s_d.prdata  = apb_req.pwrite ? 32'h0 : rdata;
        end else begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q            <= '0;
            s_q.phase      <= flow_meter_pkg::PH_BANNER1;
            s_q.warm_left  <= 9'(flow_meter_pkg::WARM_SECS);
            s_q.warm_min   <= 3'(flow_meter_pkg::WARM_MINS);
            s_q.warm_sec   <= 6'h00;
            s_q.amber      <= 1'b1;
            s_q.unit       <= flow_meter_pkg::UNIT_RST;
            s_q.tot_unit   <= flow_meter_pkg::TOT_LTR;
            s_q.table_sel  <= flow_meter_pkg::TABLE_RST;
            s_q.start_pct  <= flow_meter_pkg::START_RST;
            s_q.preset     <= flow_meter_pkg::PRESET_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        apb_rsp.prdata   = s_q.prdata;
        apb_rsp.pready   = s_q.pready;
        apb_rsp.pslverr  = s_q.pslverr;
        disp.phase       = s_q.phase;
        disp.line2_warm  = s_q.line2_warm;
        disp.warm_min    = s_q.warm_min;
        disp.warm_sec    = s_q.warm_sec;
        led_amber        = s_q.amber;
        led_green        = s_q.green;
        rate_unit        = s_q.unit;
        user_total_unit  = s_q.tot_unit;
        table_sel        = s_q.table_sel;
        gas_uncal        = s_q.uncal;
        total            = s_q.total;
        stop_hit         = s_q.stop;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_banner1_end;
        s_q.phase == flow_meter_pkg::PH_BANNER1 && s_q.ph_sec == 2'h1 && sec_tick;
    endsequence

    sequence s_banner2_end;
        s_q.phase == flow_meter_pkg::PH_BANNER2 && s_q.ph_sec == 2'h1 && sec_tick;
    endsequence

    property p_banner1;
        @(posedge pclk) disable iff (!presetn)
        s_banner1_end |=> s_q.phase == flow_meter_pkg::PH_BANNER2 ##1 disp.phase != flow_meter_pkg::PH_MAIN;
    endproperty
    a_banner1: assert property (p_banner1) else $error("first banner did not end");

    property p_banner2;
        @(posedge pclk) disable iff (!presetn)
        s_banner2_end |=> disp.phase == flow_meter_pkg::PH_MAIN;
    endproperty
    a_banner2: assert property (p_banner2) else $error("main screen not reached");

    property p_amber;
        @(posedge pclk) disable iff (!presetn)
        s_q.warm_left != 9'h0 |-> led_amber && !led_green;
    endproperty
    a_amber: assert property (p_amber) else $error("amber missing in warm-up");

    property p_green;
        @(posedge pclk) disable iff (!presetn)
        s_q.warm_left == 9'h1 && sec_tick |=> led_green && !led_amber;
    endproperty
    a_green: assert property (p_green) else $error("green missing after warm-up");

    property p_alternate;
        @(posedge pclk) disable iff (!presetn)
        s_q.diag_en && s_q.warm_left > 9'h1 && s_q.alt_sec == 2'h1 && sec_tick && !wr
        |=> disp.line2_warm != $past(disp.line2_warm);
    endproperty
    a_alternate: assert property (p_alternate) else $error("line two did not alternate");

    property p_unit_range;
        @(posedge pclk) disable iff (!presetn)
        rate_unit <= flow_meter_pkg::UNIT_USER;
    endproperty
    a_unit_range: assert property (p_unit_range) else $error("unit index out of range");

    property p_unit_pair;
        @(posedge pclk) disable iff (!presetn)
        $changed(rate_unit) |-> user_total_unit == flow_meter_pkg::tot_unit_of(rate_unit);
    endproperty
    a_unit_pair: assert property (p_unit_pair) else $error("total unit not paired");

    property p_threshold;
        @(posedge pclk) disable iff (!presetn)
        s_q.loaded && sec_tick && flow_pct < s_q.start_pct && !clr_wr && !s_q.btn2 |=> $stable(total);
    endproperty
    a_threshold: assert property (p_threshold) else $error("counted below threshold");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        s_q.loaded && !s_q.tot_en && !clr_wr && !s_q.btn2 |=> $stable(total);
    endproperty
    a_hold: assert property (p_hold) else $error("disabled total changed");

    property p_preset;
        @(posedge pclk) disable iff (!presetn)
        stop_hit == (s_q.preset != 32'h0 && total == s_q.preset);
    endproperty
    a_preset: assert property (p_preset) else $error("stop without equality");

    property p_local_clear;
        @(posedge pclk) disable iff (!presetn)
        s_q.loaded && s_q.btn2 && s_q.phase == flow_meter_pkg::PH_BANNER2 |=> total == 32'h0;
    endproperty
    a_local_clear: assert property (p_local_clear) else $error("button did not clear total");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        clr_wr |=> total == 32'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear write did not zero total");

    property p_stop_halt;
        @(posedge pclk) disable iff (!presetn)
        stop_hit && !clr_wr && !s_q.btn2 |=> $stable(total);
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("total moved after stop");

endmodule

// ### src/flow_meter_pkg.sv
/*
 Constants, types and unit map of the flow meter start-up
 and totalizer control. Assumes a 125 MHz pclk.
*/
package flow_meter_pkg;
    localparam int unsigned CLK_NS      = 8;
    localparam int unsigned SEC_NS      = 1_000_000_000;
    localparam int unsigned SEC_CYCLES  = SEC_NS / CLK_NS;
    localparam int unsigned BANNER_SECS = 2;
    localparam int unsigned WARM_MINS   = 6;
    localparam int unsigned WARM_SECS   = WARM_MINS * 60;
    localparam int unsigned ALT_SECS    = 2;

    localparam logic [4:0] UNIT_PCT   = 5'h00;
    localparam logic [4:0] UNIT_USER  = 5'h16;
    localparam logic [3:0] TABLE_LAST = 4'h9;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_UNIT   = 8'h04;
    localparam logic [7:0] ADDR_TABLE  = 8'h08;
    localparam logic [7:0] ADDR_START  = 8'h0c;
    localparam logic [7:0] ADDR_PRESET = 8'h10;
    localparam logic [7:0] ADDR_TOTAL  = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_CLR_BIT  = 1;
    localparam int unsigned CTRL_DIAG_BIT = 2;

    localparam logic [4:0]  UNIT_RST   = 5'h05;
    localparam logic [3:0]  TABLE_RST  = 4'h0;
    localparam logic [7:0]  START_RST  = 8'h00;
    localparam logic [31:0] PRESET_RST = 32'h0000_0000;

    // Totalizer unit codes
    localparam logic [3:0] TOT_PCTS = 4'h0;
    localparam logic [3:0] TOT_ML   = 4'h1;
    localparam logic [3:0] TOT_LTR  = 4'h2;
    localparam logic [3:0] TOT_M3   = 4'h3;
    localparam logic [3:0] TOT_FT3  = 4'h4;
    localparam logic [3:0] TOT_G    = 4'h5;
    localparam logic [3:0] TOT_KG   = 4'h6;
    localparam logic [3:0] TOT_LB   = 4'h7;
    localparam logic [3:0] TOT_USER = 4'h8;

    typedef enum logic [1:0] {
        PH_BANNER1 = 2'b00,
        PH_BANNER2 = 2'b01,
        PH_MAIN    = 2'b11
    } phase_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        phase_type  phase;
        logic       line2_warm;
        logic [2:0] warm_min;
        logic [5:0] warm_sec;
    } disp_type;

    function automatic logic [3:0] tot_unit_of(input logic [4:0] u);
        if (u == UNIT_PCT) return TOT_PCTS;
        if (u <= 5'h03) return TOT_ML;
        if (u <= 5'h06) return TOT_LTR;
        if (u <= 5'h09) return TOT_M3;
        if (u <= 5'h0c) return TOT_FT3;
        if (u <= 5'h0f) return TOT_G;
        if (u <= 5'h12) return TOT_KG;
        if (u <= 5'h15) return TOT_LB;
        return TOT_USER;
    endfunction
endpackage

// ### verification/apb_host_model.sv
/*
 APB host model that issues single register transfers to the
 flow meter control block. Assumes one pclk domain and a slave
 that answers with a pready pulse in the access cycle.
*/
`timescale 1ns/1ps
module apb_host_model (
    input  wire logic                        pclk,
    output      flow_meter_pkg::apb_req_type apb_req,
    input  wire flow_meter_pkg::apb_rsp_type apb_rsp
);
    initial apb_req = '0;

    // ------------------------------------------------------------
    // One transfer
    // ------------------------------------------------------------
    // Gap adds idle cycles so a slow host is exercised too; the
    // leading idle edge also keeps the release and the next setup
    // out of the same time step.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        input int gap, output logic [31:0] rdata, output logic err);
        repeat (gap + 1) @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do @(posedge pclk); while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        err   = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
endmodule

// ### verification/tb_flow_meter_startup_totalizer.sv
/*
 Self-checking bench for the flow meter control block. Assumes
 the APB host model and a second shortened to SECS cycles.
*/
`timescale 1ns/1ps
module tb_flow_meter_startup_totalizer;
    localparam int unsigned SECS = 10;

    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic [31:0] wdata;
        logic [31:0] exp;
        logic        err;
    } row_type;

    logic                        pclk;
    logic                        presetn;
    flow_meter_pkg::apb_req_type apb_req;
    flow_meter_pkg::apb_rsp_type apb_rsp;
    logic [15:0]                 flow_rate;
    logic [7:0]                  flow_pct;
    logic [9:0]                  table_valid;
    logic [31:0]                 total_restore;
    logic                        maint_button;
    flow_meter_pkg::disp_type    disp;
    logic                        led_amber;
    logic                        led_green;
    logic [4:0]                  rate_unit;
    logic [3:0]                  user_total_unit;
    logic [3:0]                  table_sel;
    logic                        gas_uncal;
    logic [31:0]                 total;
    logic                        stop_hit;
    int                          errors;
    int                          tests_run;
    int                          cyc;
    logic [31:0]                 rd_data;
    logic                        rd_err;
    logic [31:0]                 snap;
    logic                        l2;
    logic [8:0]                  exp9;
    row_type                     rows [13];
    logic [3:0]                  tot_row [23] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3,
                                                  4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h7,
                                                  4'h7, 4'h7, 4'h8};

    flow_meter_ctrl #(.SEC_CYCLES(SECS)) flow_meter_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .flow_rate(flow_rate),
        .flow_pct(flow_pct), .table_valid(table_valid), .total_restore(total_restore),
        .maint_button(maint_button), .disp(disp), .led_amber(led_amber), .led_green(led_green),
        .rate_unit(rate_unit), .user_total_unit(user_total_unit), .table_sel(table_sel),
        .gas_uncal(gas_uncal), .total(total), .stop_hit(stop_hit)
    );

    apb_host_model apb_host_model_inst (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cyc <= 0;
        else
            cyc <= cyc + 1;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_host_model_inst.xfer(1'b1, a, d, 0, rd_data, rd_err);
    endtask

    task automatic rd(input logic [7:0] a);
        apb_host_model_inst.xfer(1'b0, a, 32'h0, 0, rd_data, rd_err);
    endtask

    task automatic edges(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic wait_cyc(input int n);
        while (cyc != n) @(posedge pclk);
    endtask

    task automatic final_report();
        $display("checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Whole run is about 3630 cycles
    initial begin
        edges(20000);
        errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        maint_button = 1'b1;
        flow_rate = 16'h0007;
        flow_pct = 8'h00;
        table_valid = 10'h1ff;
        total_restore = 32'h0000_0064;
        errors = 0;
        tests_run = 0;
        rows = '{'{8'h00, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h45, 1'b0},
                 '{8'h08, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h0c, 1'b0, 32'h0, 32'h0, 1'b0},
                 '{8'h10, 1'b0, 32'h0, 32'h0, 1'b0}, '{8'h14, 1'b0, 32'h0, 32'h0, 1'b0},
                 '{8'h18, 1'b0, 32'h0, 32'h19, 1'b0}, '{8'h08, 1'b1, 32'h9, 32'h19, 1'b0},
                 '{8'h08, 1'b1, 32'ha, 32'h19, 1'b0}, '{8'h08, 1'b1, 32'h3, 32'h3, 1'b0},
                 '{8'h0c, 1'b1, 32'h32, 32'h32, 1'b0}, '{8'h10, 1'b1, 32'h0, 32'h0, 1'b0},
                 '{8'h1c, 1'b1, 32'hffff_ffff, 32'h0, 1'b1}};
        edges(12);
        presetn <= 1'b1;
        wait_cyc(8);
        chk("total with button held", 32'h0, total);
        wait_cyc(18);
        chk("phase", {30'h0, flow_meter_pkg::PH_BANNER1}, {30'h0, disp.phase});
        chk("status light", 32'h1, {30'h0, led_green, led_amber});
        wait_cyc(22);
        chk("phase", {30'h0, flow_meter_pkg::PH_BANNER2}, {30'h0, disp.phase});
        wait_cyc(38);
        chk("phase", {30'h0, flow_meter_pkg::PH_BANNER2}, {30'h0, disp.phase});
        wait_cyc(42);
        chk("phase", {30'h0, flow_meter_pkg::PH_MAIN}, {30'h0, disp.phase});
        wait_cyc(45);
        chk("warm time", {23'h0, 3'h5, 6'h38}, {23'h0, disp.warm_min, disp.warm_sec});
        wait_cyc(50);
        maint_button <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr)
                apb_host_model_inst.xfer(1'b1, rows[i].addr, rows[i].wdata, i % 2, rd_data, rd_err);
            rd(rows[i].addr);
            chk("register read", rows[i].exp, rd_data);
            chk("slave error", {31'h0, rows[i].err}, {31'h0, rd_err});
        end
        for (int u = 0; u < 24; u++) begin
            apb_host_model_inst.xfer(1'b1, flow_meter_pkg::ADDR_UNIT, 32'(u), u % 3, rd_data, rd_err);
            rd(flow_meter_pkg::ADDR_UNIT);
            exp9 = (u < 23) ? {tot_row[u], 5'(u)} : {4'h8, flow_meter_pkg::UNIT_USER};
            chk("unit register", {23'h0, exp9}, rd_data);
            chk("total unit", {28'h0, exp9[8:5]}, {28'h0, user_total_unit});
        end
        // Flow below the start threshold first, then exactly at it
        flow_pct <= 8'h28;
        wr(flow_meter_pkg::ADDR_CTRL, 32'h5);
        edges(31);
        chk("total below start", 32'h0, total);
        l2 = disp.line2_warm;
        edges(20);
        chk("line two", {31'h0, ~l2}, {31'h0, disp.line2_warm});
        flow_pct <= 8'h32;
        edges(31);
        chk("total", 32'h15, total);
        wr(flow_meter_pkg::ADDR_PRESET, 32'h1e);
        edges(31);
        chk("stopped total", 32'h1e, total);
        chk("stop", 32'h1, {31'h0, stop_hit});
        wr(flow_meter_pkg::ADDR_PRESET, 32'h0);
        edges(11);
        chk("total", 32'h25, total);
        chk("stop", 32'h0, {31'h0, stop_hit});
        wr(flow_meter_pkg::ADDR_CTRL, 32'h4);
        edges(1);
        snap = total;
        edges(31);
        chk("held total", snap, total);
        rd(flow_meter_pkg::ADDR_TOTAL);
        chk("total register", snap, rd_data);
        wr(flow_meter_pkg::ADDR_CTRL, 32'h2);
        edges(2);
        chk("cleared total", 32'h0, total);
        chk("line two", 32'h0, {31'h0, disp.line2_warm});
        wait_cyc(3598);
        chk("status light", 32'h1, {30'h0, led_green, led_amber});
        wait_cyc(3603);
        chk("status light", 32'h2, {30'h0, led_green, led_amber});
        // Second power-up without the button keeps the stored total
        presetn <= 1'b0;
        edges(12);
        presetn <= 1'b1;
        edges(2);
        chk("restored total", 32'h64, total);
        chk("unit ports", {23'h0, 4'h2, flow_meter_pkg::UNIT_RST}, {23'h0, user_total_unit, rate_unit});
        chk("table ports", 32'h0, {27'h0, gas_uncal, table_sel});
        final_report();
    end
endmodule
